// ---- common/sram_consts.svh ----
// Shared constants for the pipelined burst SRAM and its controller
`ifndef SRAM_CONSTS_SVH
`define SRAM_CONSTS_SVH
`define SRAM_DATA_W        36
`define SRAM_ADDR_W        19
`define SRAM_LANE_W        9
`define SRAM_BURST_W       2
`define SRAM_READ_LATENCY  2
`define RDATA_FIFO_DEPTH   16
`define RDATA_FIFO_MARGIN  2
`define REF_CLK_PERIOD_NS  10
`endif

// ---- common/sram_pkg.sv ----
// Types shared by both ends of the SRAM link
package sram_pkg;
  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b11
  } op_t;

  typedef enum logic {
    BURST_INTERLEAVED = 1'b0,
    BURST_LINEAR      = 1'b1
  } burst_order_t;
endpackage : sram_pkg

// ---- common/sram_if.sv ----
// Pin bundle between the SRAM device and its controller
`include "sram_consts.svh"
interface sram_if import sram_pkg::*; #(
  parameter int DW = `SRAM_DATA_W,
  parameter int AW = `SRAM_ADDR_W
);
  localparam int LN = DW / `SRAM_LANE_W;

  logic [AW-1:0] addr;
  logic          adv_ld;
  logic          we_n;
  logic [LN-1:0] byte_lane_write_n;
  logic          chip_select_one_n;
  logic          chip_select_two;
  logic          chip_select_three_n;
  logic          clock_qualify_n;
  logic          oe_n;
  logic          sleep_request;
  burst_order_t  burst_mode;
  logic [DW-1:0] dev_dq_o;
  logic          dev_dq_oe;
  logic [DW-1:0] ctl_dq_o;
  logic          ctl_dq_oe;
  logic [DW-1:0] dq;

  // Shared data wire; the output gate acts on device drive without a clock
  assign dq = (dev_dq_oe && !oe_n) ? dev_dq_o :
              ctl_dq_oe            ? ctl_dq_o : '0;

  modport device (
    input  addr, adv_ld, we_n, byte_lane_write_n, chip_select_one_n,
    input  chip_select_two, chip_select_three_n, clock_qualify_n, oe_n,
    input  sleep_request, burst_mode, dq,
    output dev_dq_o, dev_dq_oe
  );

  modport controller (
    output addr, adv_ld, we_n, byte_lane_write_n, chip_select_one_n,
    output chip_select_two, chip_select_three_n, clock_qualify_n, oe_n,
    output sleep_request, burst_mode, ctl_dq_o, ctl_dq_oe,
    input  dq
  );
endinterface : sram_if

// ---- hdl/word_fifo.sv ----
// Read data FIFO with valid and ready on both sides
module word_fifo #(
  parameter  int W     = 8,
  parameter  int DEPTH = 16,
  localparam int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  output logic [CW-1:0]      level
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } state_t;

  state_t        st;
  state_t        next_st;
  logic [W-1:0]  mem [0:DEPTH-1];
  logic          do_push;
  logic          do_pop;

  assign in_ready  = (st.cnt != CW'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data  = mem[st.rp];
  assign level     = st.cnt;
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (do_push) begin
      next_st.wp = PW'(st.wp + 1'b1);
    end
    if (do_pop) begin
      next_st.rp = PW'(st.rp + 1'b1);
    end
    next_st.cnt = CW'(st.cnt + CW'(do_push) - CW'(do_pop));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[st.wp] <= in_data;
    end
  end
endmodule : word_fifo

// ---- hdl/sram_device.sv ----
// Pipelined burst SRAM device end with self-timed writes
//
// How it works
// - Register all synchronous inputs on rising edge
// - Read data leaves through output registers
// - Qualifier high freezes pipeline and burst state; a pending array write still commits
// - Reads and writes follow back to back
// - Write strobe plus active-low lane selects update lanes
// - Array write is timed internally after capture
// - Data drivers off during write data phase
// - Three chip selects select; gate enables drive
// - Output enable timing derived internally each cycle
// - Burst order linear or interleaved by mode
// - Sleep input deselects; stopped clock keeps state
// - Array is 512K by 36 or 1M by 18
`include "sram_consts.svh"
module sram_device import sram_pkg::*; #(
  parameter int DW = `SRAM_DATA_W,
  parameter int AW = `SRAM_ADDR_W
) (
  input  wire logic REF_CLK,
  input  wire logic NRST,
  sram_if.device    BUS,
  output logic      SLEEPING
);
  localparam int LN = DW / `SRAM_LANE_W;
  localparam int LW = `SRAM_LANE_W;
  localparam int BW = `SRAM_BURST_W;

  typedef struct packed {
    op_t           s1_op;
    logic [AW-1:0] s1_addr;
    logic [LN-1:0] s1_bw;
    op_t           s2_op;
    logic [AW-1:0] s2_addr;
    logic [LN-1:0] s2_bw;
    logic          s3_wr;
    logic [AW-1:0] s3_addr;
    logic [LN-1:0] s3_bw;
    op_t           last_op;
    logic [AW-1:0] base;
    logic [BW-1:0] cnt;
    logic          wr_pend;
    logic [AW-1:0] wr_addr;
    logic [LN-1:0] wr_bw;
    logic [DW-1:0] wr_data;
    logic [DW-1:0] dout;
    logic          doe;
    logic          sleeping;
  } state_t;

  state_t         st;
  state_t         next_st;
  logic [DW-1:0]  mem [0:(1 << AW) - 1];
  logic           en;
  logic           sel;
  logic [DW-1:0]  rd_word;

  // Next address of a burst from its start and the beat count
  function automatic logic [AW-1:0] burst_addr(
    input logic [AW-1:0] start,
    input logic [BW-1:0] beat,
    input burst_order_t  order
  );
    logic [BW-1:0] low;
    if (order == BURST_LINEAR) begin
      low = BW'(start[BW-1:0] + beat);
    end else begin
      low = start[BW-1:0] ^ beat;
    end
    return {start[AW-1:BW], low};
  endfunction : burst_addr

  // Replace the lanes whose active-low select is asserted
  function automatic logic [DW-1:0] merge_lanes(
    input logic [DW-1:0] old_word,
    input logic [DW-1:0] new_word,
    input logic [LN-1:0] lane_n
  );
    logic [DW-1:0] res;
    res = old_word;
    for (int i = 0; i < LN; i++) begin
      if (!lane_n[i]) begin
        res[i*LW +: LW] = new_word[i*LW +: LW];
      end
    end
    return res;
  endfunction : merge_lanes

  always_comb begin
    en  = !BUS.clock_qualify_n;
    sel = !BUS.chip_select_one_n && BUS.chip_select_two &&
          !BUS.chip_select_three_n && !BUS.sleep_request;
    // Forward a write still waiting for the array
    rd_word = mem[st.s2_addr];
    if (st.wr_pend && (st.wr_addr == st.s2_addr)) begin
      rd_word = merge_lanes(rd_word, st.wr_data, st.wr_bw);
    end
    // Younger write whose data stands on the wire right now
    if (st.s3_wr && (st.s3_addr == st.s2_addr)) begin
      rd_word = merge_lanes(rd_word, BUS.dq, st.s3_bw);
    end
    next_st          = st;
    next_st.wr_pend  = 1'b0;
    next_st.sleeping = BUS.sleep_request;
    if (en) begin
      // Command stage moves into the data stage
      next_st.s2_op   = st.s1_op;
      next_st.s2_addr = st.s1_addr;
      next_st.s2_bw   = st.s1_bw;
      if (!sel) begin
        next_st.s1_op   = OP_IDLE;
        next_st.last_op = OP_IDLE;
      end else if (BUS.adv_ld) begin
        // Continue the running burst with the fresh lane selects
        next_st.cnt     = BW'(st.cnt + 1'b1);
        next_st.s1_op   = st.last_op;
        next_st.s1_addr = burst_addr(st.base, next_st.cnt,
                                     BUS.burst_mode);
        next_st.s1_bw   = BUS.byte_lane_write_n;
      end else begin
        next_st.s1_op   = BUS.we_n ? OP_READ : OP_WRITE;
        next_st.last_op = next_st.s1_op;
        next_st.base    = BUS.addr;
        next_st.cnt     = '0;
        next_st.s1_addr = BUS.addr;
        next_st.s1_bw   = BUS.byte_lane_write_n;
      end
      // Write data shares the wire slot of read data and is captured at the edge that ends it
      next_st.s3_wr   = (st.s2_op == OP_WRITE);
      next_st.s3_addr = st.s2_addr;
      next_st.s3_bw   = st.s2_bw;
      if (st.s3_wr) begin
        next_st.wr_pend = 1'b1;
        next_st.wr_addr = st.s3_addr;
        next_st.wr_bw   = st.s3_bw;
        next_st.wr_data = BUS.dq;
      end
      // Drivers on only for a read data phase
      next_st.doe = (st.s2_op == OP_READ) &&
                    !BUS.sleep_request;
      if (st.s2_op == OP_READ) begin
        next_st.dout = rd_word;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Array commit one edge after capture; no external pulse needed
  always_ff @(posedge REF_CLK) begin
    if (st.wr_pend) begin
      for (int i = 0; i < LN; i++) begin
        if (!st.wr_bw[i]) begin
          mem[st.wr_addr][i*LW +: LW] <= st.wr_data[i*LW +: LW];
        end
      end
    end
  end

  assign BUS.dev_dq_o  = st.dout;
  assign BUS.dev_dq_oe = st.doe;
  assign SLEEPING      = st.sleeping;
endmodule : sram_device

// ---- hdl/sram_controller.sv ----
// Memory controller end: issues commands, drives write data, buffers reads
`include "sram_consts.svh"
module sram_controller import sram_pkg::*; #(
  parameter int DW    = `SRAM_DATA_W,
  parameter int AW    = `SRAM_ADDR_W,
  parameter int DEPTH = `RDATA_FIFO_DEPTH
) (
  input  wire logic                            REF_CLK,
  input  wire logic                            NRST,
  sram_if.controller                           BUS,
  input  wire logic                            REQ_VALID,
  output logic                                 REQ_READY,
  input  wire logic                            REQ_WRITE,
  input  wire logic                            REQ_BURST,
  input  wire logic [AW-1:0]                   REQ_ADDR,
  input  wire logic [DW/`SRAM_LANE_W-1:0]      REQ_LANES,
  input  wire logic [DW-1:0]                   REQ_DATA,
  input  wire logic                            STALL,
  input  wire logic                            SLEEP,
  input  wire burst_order_t                    MODE,
  output logic                                 RD_VALID,
  input  wire logic                            RD_READY,
  output logic [DW-1:0]                        RD_DATA
);
  localparam int LN = DW / `SRAM_LANE_W;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    op_t           c0_op;
    logic [DW-1:0] c0_data;
    op_t           c1_op;
    logic [DW-1:0] c1_data;
    op_t           c2_op;
    logic [DW-1:0] c2_data;
    op_t           c3_op;
    op_t           last_op;
    logic [AW-1:0] addr;
    logic          adv_ld;
    logic          we_n;
    logic [LN-1:0] bw_n;
    logic          cs_on;
    logic          qualify_n;
    logic          sleep;
    burst_order_t  mode;
    logic [DW-1:0] dq_o;
    logic          dq_oe;
    logic          ready;
  } state_t;

  state_t         st;
  state_t         next_st;
  logic           en;
  logic           take;
  logic           push;
  logic           fifo_in_ready;
  logic [CW-1:0]  fifo_level;
  int             reads;
  int             free;

  always_comb begin
    en    = !st.qualify_n;
    take  = REQ_VALID && st.ready;
    push  = en && (st.c3_op == OP_READ);
    reads = int'(st.c0_op == OP_READ) + int'(st.c1_op == OP_READ) +
            int'(st.c2_op == OP_READ) + int'(st.c3_op == OP_READ);
    free  = DEPTH - int'(fifo_level) - reads - int'(take);
    next_st           = st;
    next_st.qualify_n = STALL;
    // Sleep waits until no fresh command or read still needs the pins
    next_st.sleep     = SLEEP && !take && (st.c0_op != OP_READ) &&
                        (st.c1_op != OP_READ);
    next_st.mode      = MODE;
    next_st.ready     = !STALL && !SLEEP && fifo_in_ready &&
                        (free >= `RDATA_FIFO_MARGIN);
    if (en) begin
      next_st.c1_op   = st.c0_op;
      next_st.c1_data = st.c0_data;
      next_st.c2_op   = st.c1_op;
      next_st.c2_data = st.c1_data;
      next_st.c3_op   = st.c2_op;
      // Write data in the slot a read would use, so turnarounds never clash
      next_st.dq_o    = st.c2_data;
      next_st.dq_oe   = (st.c2_op == OP_WRITE);
      if (take) begin
        next_st.cs_on   = 1'b1;
        next_st.adv_ld  = REQ_BURST;
        next_st.addr    = REQ_ADDR;
        next_st.we_n    = !REQ_WRITE;
        next_st.bw_n    = ~REQ_LANES;
        next_st.c0_data = REQ_DATA;
        next_st.c0_op   = REQ_BURST ? st.last_op :
                          (REQ_WRITE ? OP_WRITE : OP_READ);
        next_st.last_op = next_st.c0_op;
      end else begin
        next_st.cs_on   = 1'b0;
        next_st.adv_ld  = 1'b0;
        next_st.we_n    = 1'b1;
        next_st.bw_n    = '1;
        next_st.c0_op   = OP_IDLE;
        next_st.last_op = OP_IDLE;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      st           <= '0;
      st.we_n      <= 1'b1;
      st.bw_n      <= '1;
      st.qualify_n <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  word_fifo #(
    .W     (DW),
    .DEPTH (DEPTH)
  ) u_rdata_fifo (
    .clk       (REF_CLK),
    .rst_n     (NRST),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (BUS.dq),
    .out_valid (RD_VALID),
    .out_ready (RD_READY),
    .out_data  (RD_DATA),
    .level     (fifo_level)
  );

  assign BUS.addr                = st.addr;
  assign BUS.adv_ld              = st.adv_ld;
  assign BUS.we_n                = st.we_n;
  assign BUS.byte_lane_write_n   = st.bw_n;
  assign BUS.chip_select_one_n   = !st.cs_on;
  assign BUS.chip_select_two     = st.cs_on;
  assign BUS.chip_select_three_n = !st.cs_on;
  assign BUS.clock_qualify_n     = st.qualify_n;
  assign BUS.oe_n                = 1'b0;
  assign BUS.sleep_request       = st.sleep;
  assign BUS.burst_mode          = st.mode;
  assign BUS.ctl_dq_o            = st.dq_o;
  assign BUS.ctl_dq_oe           = st.dq_oe;
  assign REQ_READY               = st.ready;
endmodule : sram_controller

// ---- verification/sram_link_assertions.sv ----
// Pin link checks between the SRAM device and its controller
module sram_link_assertions #(
  parameter int DW = 36
) (
  input wire logic          REF_CLK,
  input wire logic          NRST,
  input wire logic          adv_ld,
  input wire logic          we_n,
  input wire logic          chip_select_one_n,
  input wire logic          chip_select_two,
  input wire logic          chip_select_three_n,
  input wire logic          clock_qualify_n,
  input wire logic          sleep_request,
  input wire logic [DW-1:0] dev_dq_o,
  input wire logic          dev_dq_oe,
  input wire logic [DW-1:0] ctl_dq_o,
  input wire logic          ctl_dq_oe
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  logic en;
  logic sel;
  assign en  = !clock_qualify_n;
  assign sel = en && !chip_select_one_n && chip_select_two
               && !chip_select_three_n && !sleep_request;
  sequence rd_load; sel && !adv_ld && we_n; endsequence
  sequence wr_load; sel && !adv_ld && !we_n; endsequence
  sequence awake_edge; en && !sleep_request; endsequence
  sequence two_edges; awake_edge ##1 awake_edge; endsequence
  chk_bus_exclusive:
  assert property (!(dev_dq_oe && ctl_dq_oe)) else $error("dq driven twice");
  chk_read_drive:
  assert property (rd_load ##1 two_edges |=> dev_dq_oe)
    else $error("read data not driven");
  chk_burst_drive:
  assert property (rd_load ##1 (sel && adv_ld) ##1 two_edges |=> dev_dq_oe)
    else $error("burst beat not driven");
  chk_write_data:
  assert property (wr_load ##1 en ##1 en |=> ctl_dq_oe)
    else $error("write data missing");
  chk_write_tristate:
  assert property (wr_load ##1 en ##1 en |=> !dev_dq_oe)
    else $error("device drives in write phase");
  chk_idle_quiet:
  assert property ((en && !sel) ##1 two_edges |=> !dev_dq_oe)
    else $error("device drives after idle");
  chk_freeze_dev:
  assert property (clock_qualify_n |=> $stable(dev_dq_oe) && $stable(dev_dq_o))
    else $error("device moved on ignored edge");
  chk_freeze_ctl:
  assert property (clock_qualify_n |=> $stable(ctl_dq_oe) && $stable(ctl_dq_o))
    else $error("controller moved on ignored edge");
  chk_sleep_quiet:
  assert property ((en && sleep_request) [*2] |=> !dev_dq_oe)
    else $error("device drives in sleep");
endmodule : sram_link_assertions

// ---- verification/tb_pipelined_burst_sram_core.sv ----
// Self-checking bench for the SRAM device and controller pair
`include "sram_consts.svh"
module tb_pipelined_burst_sram_core import sram_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DW = `SRAM_DATA_W;
  localparam int AW = `SRAM_ADDR_W;
  localparam int LN = DW / `SRAM_LANE_W;
  localparam int DEPTH = `RDATA_FIFO_DEPTH;
  logic          REF_CLK;
  logic          NRST;
  logic          req_valid, req_ready, req_write, req_burst;
  logic          stall, sleep, rd_valid, rd_ready, sleeping;
  logic [AW-1:0] req_addr;
  logic [LN-1:0] req_lanes;
  logic [DW-1:0] req_data, rd_data;
  burst_order_t  mode;
  logic [DW-1:0] model [int];
  logic [DW-1:0] expq [$];
  int            fails, num_checks, cycles, taken;

  sram_if #(.DW(DW), .AW(AW)) u_sram_if ();
  sram_device #(.DW(DW), .AW(AW)) u_sram_device (.REF_CLK(REF_CLK),
    .NRST(NRST), .BUS(u_sram_if.device), .SLEEPING(sleeping));
  sram_controller #(.DW(DW), .AW(AW), .DEPTH(DEPTH)) u_sram_controller (
    .REF_CLK(REF_CLK), .NRST(NRST), .BUS(u_sram_if.controller),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_WRITE(req_write),
    .REQ_BURST(req_burst), .REQ_ADDR(req_addr), .REQ_LANES(req_lanes),
    .REQ_DATA(req_data), .STALL(stall), .SLEEP(sleep), .MODE(mode),
    .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data));
  sram_link_assertions #(.DW(DW)) u_sram_link_assertions (
    .REF_CLK(REF_CLK), .NRST(NRST), .adv_ld(u_sram_if.adv_ld),
    .we_n(u_sram_if.we_n), .chip_select_one_n(u_sram_if.chip_select_one_n),
    .chip_select_two(u_sram_if.chip_select_two),
    .chip_select_three_n(u_sram_if.chip_select_three_n),
    .clock_qualify_n(u_sram_if.clock_qualify_n),
    .sleep_request(u_sram_if.sleep_request), .dev_dq_o(u_sram_if.dev_dq_o),
    .dev_dq_oe(u_sram_if.dev_dq_oe), .ctl_dq_o(u_sram_if.ctl_dq_o),
    .ctl_dq_oe(u_sram_if.ctl_dq_oe));

  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [DW-1:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [DW-1:0] pat(input int i);
    return DW'(36'h9_3c5a_0f01 * (i + 1));
  endfunction : pat

  // Holds the request until taken; the model follows lane by lane
  task automatic issue(input logic wr, bst, input logic [AW-1:0] a,
                       input logic [LN-1:0] ln, input logic [DW-1:0] d);
    logic [DW-1:0] m;
    req_valid = 1'b1;
    req_write = wr;
    req_burst = bst;
    req_addr = a;
    req_lanes = ln;
    req_data = d;
    @(posedge REF_CLK);
    while (req_ready !== 1'b1) @(posedge REF_CLK);
    #1;
    for (int i = 0; i < LN; i++) m[i*`SRAM_LANE_W +: `SRAM_LANE_W] = {9{ln[i]}};
    if (wr) model[a] = (model[a] & ~m) | (d & m);
    else expq.push_back(model[a]);
  endtask : issue

  task automatic drain();
    req_valid = 1'b0;
    while (expq.size() != 0) @(posedge REF_CLK);
    #1;
  endtask : drain

  always @(posedge REF_CLK) begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
      check("read data", expq.size() > 0 ? expq.pop_front() : 'x, rd_data);
  end

  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("[FAIL] timeout expected done seen hang");
      finish_test();
    end
  end

  initial begin
    NRST = 1'b0;
    {req_valid, req_write, req_burst, stall, sleep} = '0;
    req_addr = '0;
    req_lanes = '0;
    req_data = '0;
    rd_ready = 1'b1;
    mode = BURST_LINEAR;
    repeat (3) @(posedge REF_CLK);
    #1 NRST = 1'b1;
    // Back to back writes, then read, write, read turnarounds for each address
    for (int i = 0; i < 8; i++) issue(1, 0, AW'(i), '1, pat(i));
    for (int i = 0; i < 8; i++) begin
      issue(0, 0, AW'(i), '0, '0);
      issue(1, 0, AW'(i), '1, ~pat(i));
      issue(0, 0, AW'(i), '0, '0);
    end
    // One lane at a time over a cleared word
    for (int l = 0; l < LN; l++) begin
      issue(1, 0, AW'(40 + l), '1, '0);
      issue(1, 0, AW'(40 + l), LN'(1) << l, '1);
      issue(0, 0, AW'(40 + l), '0, '0);
    end
    drain();
    // Burst from word 5 of the block at 4 in both orders
    for (int m = 0; m < 2; m++) begin
      mode = burst_order_t'(m);
      repeat (3) @(posedge REF_CLK);
      #1;
      issue(0, 0, AW'(5), '0, '0);
      for (int b = 1; b < 4; b++)
        issue(0, 1, AW'(m ? 4 + ((1 + b) % 4) : 4 + (1 ^ b)), '0, '0);
      drain();
    end
    // Qualifier stall in the middle of a read stream
    fork
      begin
        repeat (3) @(posedge REF_CLK);
        #1 stall = 1'b1;
        repeat (4) @(posedge REF_CLK);
        #1 stall = 1'b0;
      end
      for (int i = 0; i < 8; i++) issue(0, 0, AW'(i), '0, '0);
    join
    drain();
    // Sleep refuses requests and keeps the array
    sleep = 1'b1;
    repeat (4) @(posedge REF_CLK);
    #1;
    check("sleep flag", 1, sleeping);
    check("ready in sleep", 0, req_ready);
    sleep = 1'b0;
    for (int i = 0; i < 4; i++) issue(0, 0, AW'(i), '0, '0);
    drain();
    // Read FIFO filled while the consumer stalls, then emptied
    rd_ready = 1'b0;
    taken = 0;
    {req_valid, req_write, req_burst, req_addr} = {3'b100, AW'(3)};
    repeat (30) begin
      @(posedge REF_CLK);
      if (req_ready === 1'b1) begin
        taken++;
        expq.push_back(model[3]);
      end
    end
    #1;
    req_valid = 1'b0;
    check("ready when full", 0, req_ready);
    check("fifo words", 1, taken >= DEPTH - 2 && taken <= DEPTH);
    rd_ready = 1'b1;
    drain();
    check("fifo empty", 0, rd_valid);
    finish_test();
  end
endmodule : tb_pipelined_burst_sram_core
